// File: hdl/tsa_pkg.sv
// Constants shared by the time slot assigner and its serial receiver.
// Assumes a SystemVerilog compiler that accepts packed arrays in structs.
package tsa_pkg;

   // -------------------------------------------------------------------
   // Serial word layout
   // -------------------------------------------------------------------
   localparam int unsigned WORD_W  = 8;       // Bits per serial word
   localparam logic [3:0]  CNT_LAST = 4'h7;   // Index of the last bit
   localparam int unsigned MODE_HI = 7;       // First-sent mode bit
   localparam int unsigned MODE_LO = 6;       // Second-sent mode bit
   localparam int unsigned SLOT_HI = 5;       // Time slot field top
   localparam int unsigned SLOT_W  = 6;       // Time slot field width
   localparam int unsigned STAT_HI = 7;       // Status field q2
   localparam int unsigned STAT_LO = 5;       // Status field q0
   localparam int unsigned ID_HI   = 4;       // Address field top
   localparam int unsigned ID_W    = 5;       // Address field width

   // -------------------------------------------------------------------
   // Frame timing
   // -------------------------------------------------------------------
   localparam int unsigned CNT_W    = 9;       // Bit counter, 64 slots
   localparam logic [8:0]  CNT_MAX  = 9'h1ff;  // Counter stop value
   localparam int unsigned SLOT_LSB = 3;       // Eight bits per slot
   localparam logic [1:0]  ACK_DELAY = 2'h3;   // Data clocks to ack
   localparam int unsigned DIR_TX   = 0;       // Transmit direction
   localparam int unsigned DIR_RX   = 1;       // Receive direction

   // Programming modes, first-sent bit is the upper one
   typedef enum logic [1:0]
   {
      MODE_BOTH,   // Load both directions
      MODE_TX,     // Load transmit only
      MODE_RX,     // Load receive only
      MODE_IDLE    // Disable both enables
   } tsa_mode_t;

endpackage

// File: hdl/tsa_serial_rx.sv
// Serial programming receiver, runs on the processor's serial clock.
// Assumes chip select is low between accesses and clears this logic.
`timescale 1ns/1ps

module tsa_serial_rx
   import tsa_pkg::*;
(
   input  wire logic             prog_clk,
   input  wire logic             chip_select,
   input  wire logic             slot_mode_serial_in,
   input  wire logic             addr_status_serial_in,
   output logic [WORD_W-1:0]     mode_word,
   output logic [WORD_W-1:0]     addr_word,
   output logic                  word_done
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed
   {
      logic [3:0]        cnt;   // Bits received so far
      logic [WORD_W-1:0] ms;    // Mode and slot shifter
      logic [WORD_W-1:0] as;    // Address and status shifter
      logic              done;  // Full word held, level
   } tsa_rx_st_t;

   tsa_rx_st_t st;       // Registered state
   tsa_rx_st_t next_st;  // Next state

   // Shift both lines together, freeze after the eighth bit
   always_comb
   begin
      next_st = st;
      if (!st.done)
      begin
         next_st.ms  = {st.ms[WORD_W-2:0], slot_mode_serial_in};
         next_st.as  = {st.as[WORD_W-2:0], addr_status_serial_in};
         next_st.cnt = st.cnt + 4'h1;
         if (st.cnt == CNT_LAST)
         begin
            next_st.done = 1'b1;
         end
      end
   end

   // Falling edge sampling; chip select low drops a partial word
   // and restarts the count, since the clock may stop outside frames.
   always_ff @(negedge prog_clk or negedge chip_select)
   begin
      if (!chip_select)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign mode_word = st.ms;
   assign addr_word = st.as;
   assign word_done = st.done;

   // Done only after exactly eight bits
   property p_eight_bits;
      @(negedge prog_clk) disable iff (!chip_select)
      $rose(st.done) |-> $past(st.cnt) == CNT_LAST;
   endproperty
   a_eight_bits: assert property (p_eight_bits)
      else $error("word done without eight bits");

endmodule // tsa_serial_rx

// File: hdl/tsa_top.sv
// Time slot assigner: serial load, address match, slot enables, ack.
// Assumes the data clock and frame syncs are far slower than clk.
//
// What this block does
// - Serial bits sampled on falling serial clock
// - Eight mode/slot bits shift after select rises
// - First two bits mode, last six slot
// - Address/status word shifts alongside, bit per edge
// - First three address bits are q2,q1,q0
// - Accept only when five address bits match
// - Unique addresses, one of 32 accepts
// - Select enables bank, address picks unit
// - Ring trip input forces q2 low immediately
// - Serial values cross safely into data domain
// - Separate transmit and receive slot enables
// - Enable high eight clocks at programmed slot
// - Clock rise with sync rise is slot zero
// - Ack low three clocks after sync, till next
// - Idle mode disables enables, still updates status
`timescale 1ns/1ps

module tsa_top
   import tsa_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire logic            prog_clk,
   input  wire logic            chip_select,
   input  wire logic            slot_mode_serial_in,
   input  wire logic            addr_status_serial_in,
   input  wire logic [ID_W-1:0] hardwired_unit_id,
   input  wire logic            ring_trip_clear,
   input  wire logic            bit_clock_a,
   input  wire logic            tx_frame_sync,
   input  wire logic            rx_frame_sync,
   input  wire logic            ack_in,
   output logic                 ack_out,
   output logic                 ack_oe,
   output logic                 tx_slot_enable,
   output logic                 rx_slot_enable,
   output logic                 status_out_bit0,
   output logic                 status_out_bit1,
   output logic                 status_out_bit2
);

   // -------------------------------------------------------------------
   // Serial receiver in the programming clock domain
   // -------------------------------------------------------------------
   logic [WORD_W-1:0] rx_mode_word;  // Held mode and slot word
   logic [WORD_W-1:0] rx_addr_word;  // Held address and status word
   logic              rx_word_done;  // Word complete, level

   tsa_serial_rx u_rx
   (
      .prog_clk              (prog_clk),
      .chip_select           (chip_select),
      .slot_mode_serial_in   (slot_mode_serial_in),
      .addr_status_serial_in (addr_status_serial_in),
      .mode_word             (rx_mode_word),
      .addr_word             (rx_addr_word),
      .word_done             (rx_word_done)
   );

   // -------------------------------------------------------------------
   // State of the system clock domain
   // -------------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0]             dc_sy;     // Data clock synchroniser
      logic [1:0][1:0]        fs_sy;     // Frame sync synchronisers
      logic [1:0]             done_sy;   // Word done synchroniser
      logic [1:0]             rt_sy;     // Ring trip synchroniser
      logic [1:0][ID_W-1:0]   id_sy;     // Address pin synchroniser
      logic                   dc_prev;   // Data clock last sample
      logic [1:0]             fs_prev;   // Sync level at last clock rise
      logic                   done_prev; // Done last sample
      logic                   pending;   // Accepted word waiting
      logic [WORD_W-1:0]      pend_ms;   // Waiting mode and slot
      logic [WORD_W-1:0]      pend_as;   // Waiting status and address
      logic [1:0][SLOT_W-1:0] slot;      // Programmed slot numbers
      logic [1:0]             act;       // Direction enabled
      logic [1:0][CNT_W-1:0]  cnt;       // Bit position in frame
      logic [1:0]             run;       // Counter running
      logic [1:0]             en;        // Slot enable outputs
      logic [2:0]             q;         // Status bits q2..q0
      logic [1:0]             ack_cnt;   // Clocks left before ack
      logic                   ack_drive; // Pulling ack low
   } tsa_st_t;

   tsa_st_t st;       // Registered state
   tsa_st_t next_st;  // Next state

   // -------------------------------------------------------------------
   // Decoded events, edges from second synchroniser stages
   // -------------------------------------------------------------------
   logic       dc_rise;    // Data clock rising edge seen
   logic [1:0] fs_edge;    // Frame sync edge, per direction
   logic       done_rise;  // New word from the serial side
   logic       id_match;   // Address field equals pins
   logic [1:0] fs_pin;     // Frame sync pins by direction

   assign fs_pin = {rx_frame_sync, tx_frame_sync};

   // Edge and match detection
   always_comb
   begin
      dc_rise   = st.dc_sy[1] & ~st.dc_prev;
      done_rise = st.done_sy[1] & ~st.done_prev;
      // A word is ours only if all five address bits agree
      id_match  = (rx_addr_word[ID_HI:0] == st.id_sy[1]);
      for (int d = 0; d < 2; d++)
      begin
         // Sync sampled at each clock rise; rising pair marks slot 0
         fs_edge[d] = dc_rise & st.fs_sy[d][1] & ~st.fs_prev[d];
      end
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb
   begin
      next_st = st;

      // Two-stage synchronisers for every foreign input but the held words
      next_st.dc_sy   = {st.dc_sy[0], bit_clock_a};
      next_st.done_sy = {st.done_sy[0], rx_word_done};
      next_st.rt_sy   = {st.rt_sy[0], ring_trip_clear};
      next_st.id_sy   = {st.id_sy[0], hardwired_unit_id};
      for (int d = 0; d < 2; d++)
      begin
         next_st.fs_sy[d] = {st.fs_sy[d][0], fs_pin[d]};
      end
      next_st.dc_prev   = st.dc_sy[1];
      next_st.done_prev = st.done_sy[1];
      if (dc_rise)
      begin
         next_st.fs_prev = {st.fs_sy[1][1], st.fs_sy[0][1]};
      end

      // Apply a waiting word on the transmit frame edge only
      if (fs_edge[DIR_TX])
      begin
         next_st.ack_drive = 1'b0;
         if (st.pending)
         begin
            next_st.pending = 1'b0;
            next_st.ack_cnt = ACK_DELAY;
            // Status loads in every accepted mode, idle included
            next_st.q = st.pend_as[STAT_HI:STAT_LO];
            unique case (tsa_mode_t'(st.pend_ms[MODE_HI:MODE_LO]))
               MODE_BOTH:
               begin
                  next_st.slot[DIR_TX] = st.pend_ms[SLOT_HI:0];
                  next_st.slot[DIR_RX] = st.pend_ms[SLOT_HI:0];
                  next_st.act          = 2'h3;
               end
               MODE_TX:
               begin
                  // Receive side left as it was
                  next_st.slot[DIR_TX] = st.pend_ms[SLOT_HI:0];
                  next_st.act[DIR_TX]  = 1'b1;
               end
               MODE_RX:
               begin
                  // Transmit side left as it was
                  next_st.slot[DIR_RX] = st.pend_ms[SLOT_HI:0];
                  next_st.act[DIR_RX]  = 1'b1;
               end
               MODE_IDLE:
               begin
                  next_st.act = 2'h0;
               end
            endcase
         end
      end
      else if (dc_rise && (st.ack_cnt != 2'h0))
      begin
         // Count data clocks after the frame edge
         next_st.ack_cnt = st.ack_cnt - 2'h1;
         if (st.ack_cnt == 2'h1)
         begin
            next_st.ack_drive = 1'b1;
         end
      end

      // Capture after apply, so a word arriving on the edge survives.
      // Select reaches the whole bank; only a matching unit captures.
      if (done_rise && id_match)
      begin
         next_st.pending = 1'b1;
         next_st.pend_ms = rx_mode_word;
         next_st.pend_as = rx_addr_word;
      end

      // Ring trip clears q2 and wins over any status load
      if (st.rt_sy[1])
      begin
         next_st.q[2] = 1'b0;
      end

      // Per direction frame counters and slot windows
      for (int d = 0; d < 2; d++)
      begin
         if (fs_edge[d])
         begin
            next_st.cnt[d] = '0;
            next_st.run[d] = 1'b1;
         end
         else if (dc_rise && st.run[d])
         begin
            // Stop at the end so a missing sync gives no second window
            if (st.cnt[d] == CNT_MAX)
            begin
               next_st.run[d] = 1'b0;
            end
            else
            begin
               next_st.cnt[d] = st.cnt[d] + 9'h001;
            end
         end
         // Window is the eight bits of the programmed slot
         next_st.en[d] = next_st.run[d] & next_st.act[d] &
            (next_st.cnt[d][CNT_W-1:SLOT_LSB] == next_st.slot[d]);
      end

      if (reset)
      begin
         next_st = '0;
      end
   end

   // Single register for the whole state
   always_ff @(posedge clk)
   begin
      st <= next_st;
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign tx_slot_enable  = st.en[DIR_TX];
   assign rx_slot_enable  = st.en[DIR_RX];
   assign status_out_bit0 = st.q[0];
   assign status_out_bit1 = st.q[1];
   // Raw pin gate keeps the forced low free of synchroniser delay
   assign status_out_bit2 = st.q[2] & ~ring_trip_clear;
   // Open drain: only ever drives low, pull-up sits outside
   assign ack_out         = 1'b0;
   assign ack_oe          = st.ack_drive;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_apply;
      fs_edge[DIR_TX] && st.pending;
   endsequence

   // Countdown loaded and the wire released, one clock after apply
   sequence s_ack_wait;
      (st.ack_cnt == ACK_DELAY) && !ack_oe;
   endsequence

   property p_ring_trip;
      ring_trip_clear |-> !status_out_bit2;
   endproperty
   a_ring_trip: assert property (p_ring_trip)
      else $error("q2 high during ring trip");

   property p_ack_start;
      s_apply |=> s_ack_wait;
   endproperty
   a_ack_start: assert property (p_ack_start)
      else $error("ack countdown not started on frame edge");

   property p_ack_release;
      fs_edge[DIR_TX] |=> !ack_oe;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("ack not released on frame edge");

   property p_ack_rise;
      $rose(ack_oe) |-> $past(dc_rise) && $past(st.ack_cnt) == 2'h1;
   endproperty
   a_ack_rise: assert property (p_ack_rise)
      else $error("ack drove at wrong data clock");

   property p_no_match;
      done_rise && !id_match && !st.pending |=> !st.pending;
   endproperty
   a_no_match: assert property (p_no_match)
      else $error("word accepted with wrong address");

   property p_idle;
      !st.act[DIR_TX] |-> !tx_slot_enable;
   endproperty
   a_idle: assert property (p_idle)
      else $error("transmit enable while idle");

   property p_slot_pos;
      tx_slot_enable |-> st.cnt[DIR_TX][CNT_W-1:SLOT_LSB] == st.slot[DIR_TX];
   endproperty
   a_slot_pos: assert property (p_slot_pos)
      else $error("transmit enable outside its slot");

   property p_slot_start;
      $rose(rx_slot_enable) |-> st.cnt[DIR_RX][SLOT_LSB-1:0] == 3'h0;
   endproperty
   a_slot_start: assert property (p_slot_start)
      else $error("receive enable off slot boundary");

   property p_frame_zero;
      fs_edge[DIR_RX] |=> st.cnt[DIR_RX] == '0 && st.run[DIR_RX];
   endproperty
   a_frame_zero: assert property (p_frame_zero)
      else $error("frame edge did not mark bit zero");

   property p_apply_edge;
      $changed(st.slot[DIR_TX]) || $changed(st.q[1]) |-> $past(fs_edge[DIR_TX]);
   endproperty
   a_apply_edge: assert property (p_apply_edge)
      else $error("settings changed mid frame");

   property p_pend_cause;
      $rose(st.pending) |-> $past(done_rise) && $past(id_match);
   endproperty
   a_pend_cause: assert property (p_pend_cause)
      else $error("word taken without synchronised done");

endmodule // tsa_top

// File: tb/time_slot_assigner_test.sv
// Self-checking bench for the time slot assigner top.
// Assumes the processor model and the design package are compiled first.
`timescale 1ns/1ps

module time_slot_assigner_test
   import tsa_pkg::*;
;
   localparam int         FRAME   = 40;     // Short frame keeps runs brief
   localparam int         RXOFF   = 5;      // Receive frame lag in bits
   localparam logic [4:0] UNIT_ID = 5'h10;  // Pins of the unit under test

   typedef struct packed
   {
      logic [1:0] mode;
      logic [5:0] slot;
      logic [2:0] q;
      logic [4:0] id;
      logic       acc;
   } tsa_row_t;

   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       bit_clock_a = 1'b0;
   logic       tx_frame_sync = 1'b0;
   logic       rx_frame_sync = 1'b0;
   logic       ring_trip_clear = 1'b0;
   logic [4:0] hardwired_unit_id = UNIT_ID;
   logic       prog_clk, chip_select, smi, asi, ack_wire;
   logic       ack_out, ack_oe, tx_slot_enable, rx_slot_enable;
   logic       status_out_bit0, status_out_bit1, status_out_bit2;
   int         ph = 7;                      // Clock phase within a bit
   int         fbit = FRAME - 1;            // Transmit frame bit
   int         rbit = 0;                    // Receive frame bit
   int         err_count = 0;
   int         n_checks = 0;
   int         ack_count = 0;
   logic       mon_on = 1'b0;
   int         tx_s = 0;                    // Expected slots and activity
   int         rx_s = 0;
   logic       tx_a = 1'b0;
   logic       rx_a = 1'b0;
   logic [2:0] q_e = 3'h0;
   tsa_row_t   rows [6];

   // Open-drain ack with weak pull-up
   assign ack_wire = ack_oe ? ack_out : 1'b1;

   tsa_top i_dut (.clk(clk), .reset(reset), .prog_clk(prog_clk),
      .chip_select(chip_select), .slot_mode_serial_in(smi),
      .addr_status_serial_in(asi), .hardwired_unit_id(hardwired_unit_id),
      .ring_trip_clear(ring_trip_clear), .bit_clock_a(bit_clock_a),
      .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync),
      .ack_in(ack_wire), .ack_out(ack_out), .ack_oe(ack_oe),
      .tx_slot_enable(tx_slot_enable), .rx_slot_enable(rx_slot_enable),
      .status_out_bit0(status_out_bit0), .status_out_bit1(status_out_bit1),
      .status_out_bit2(status_out_bit2));

   tsa_proc_model i_proc (.prog_clk(prog_clk), .chip_select(chip_select),
      .slot_mode_serial_in(smi), .addr_status_serial_in(asi),
      .ack_wire(ack_wire));

   // ----------------------------------------------------------------
   // Clocks and frame timing
   // ----------------------------------------------------------------
   always #25 clk = ~clk;

   // Data clock of eight system clocks; syncs rise on its falling edge
   always @(posedge clk)
   begin
      #2;
      ph = (ph + 1) % 8;
      if (ph == 0)
         fbit = (fbit + 1) % FRAME;
      rbit = (fbit + FRAME - RXOFF) % FRAME;
      bit_clock_a = (ph < 4);
      tx_frame_sync = (fbit == FRAME - 1 && ph >= 4) || (fbit == 0 && ph < 4);
      rx_frame_sync = (rbit == FRAME - 1 && ph >= 4) || (rbit == 0 && ph < 4);
   end

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Waits, bounded, for a given bit and phase
   task automatic to_phase(input int b, input int p);
      int i;
      for (i = 0; i < 400 && !(fbit == b && ph == p); i++)
      begin
         @(posedge clk);
         #3;
      end
      check("phase_reached", {7'h0, (fbit == b && ph == p)}, 8'h01);
   endtask

   // Samples both enables mid-bit over one whole frame
   task automatic check_frame();
      int b;
      to_phase(0, 0);
      for (b = 0; b < FRAME; b++)
      begin
         to_phase(b, 6);
         check("tx_slot_enable", tx_slot_enable, tx_a && b >= tx_s*8 && b < tx_s*8+8);
         check("rx_slot_enable", rx_slot_enable, rx_a && rbit >= rx_s*8 && rbit < rx_s*8+8);
      end
      check("status", {status_out_bit2, status_out_bit1, status_out_bit0}, q_e);
   endtask

   // Ack must turn on at bit three and off at the next frame edge
   always @(posedge ack_oe)
      if (mon_on)
      begin
         ack_count++;
         check("ack_on_bit", fbit, 3);
      end

   always @(negedge ack_oe)
      if (mon_on)
         check("ack_off_bit", fbit, 0);

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin : main
      int r;
      logic acked;
      rows[0] = {MODE_BOTH, 6'h02, 3'h3, UNIT_ID, 1'b1};
      rows[1] = {MODE_TX, 6'h04, 3'h5, UNIT_ID, 1'b1};
      rows[2] = {MODE_RX, 6'h01, 3'h6, UNIT_ID, 1'b1};
      rows[3] = {MODE_TX, 6'h03, 3'h0, 5'h11, 1'b0};   // One address bit off
      rows[4] = {MODE_IDLE, 6'h3f, 3'h1, UNIT_ID, 1'b1};
      rows[5] = {MODE_BOTH, 6'h00, 3'h7, UNIT_ID, 1'b1};
      repeat (6) @(posedge clk);
      #2 reset = 1'b0;
      mon_on = 1'b1;
      check_frame();
      // Ordinary loads, one row each
      for (r = 0; r < 6; r++)
      begin
         i_proc.access({rows[r].mode, rows[r].slot}, {rows[r].q, rows[r].id}, 8, acked);
         check("acked", acked, rows[r].acc);
         if (rows[r].acc)
         begin
            q_e = rows[r].q;
            if (rows[r].mode == MODE_BOTH || rows[r].mode == MODE_TX)
            begin
               tx_s = rows[r].slot;
               tx_a = 1'b1;
            end
            if (rows[r].mode == MODE_BOTH || rows[r].mode == MODE_RX)
            begin
               rx_s = rows[r].slot;
               rx_a = 1'b1;
            end
            if (rows[r].mode == MODE_IDLE)
            begin
               tx_a = 1'b0;
               rx_a = 1'b0;
            end
         end
         check_frame();
      end
      // Reset in mid-run clears everything
      @(posedge clk);
      #2 reset = 1'b1;
      repeat (6) @(posedge clk);
      #2 reset = 1'b0;
      tx_a = 1'b0;
      rx_a = 1'b0;
      q_e = 3'h0;
      check_frame();
      // Partial word is dropped, next whole word still lands
      i_proc.access({MODE_BOTH, 6'h00}, {3'h4, UNIT_ID}, 5, acked);
      check("partial_acked", acked, 1'b0);
      i_proc.access({MODE_TX, 6'h03}, {3'h5, UNIT_ID}, 8, acked);
      check("full_acked", acked, 1'b1);
      tx_s = 3;
      tx_a = 1'b1;
      q_e = 3'h5;
      check_frame();
      // Ring trip clears the third status output at once
      @(posedge clk);
      #2 ring_trip_clear = 1'b1;
      #1 check("q2_forced", status_out_bit2, 1'b0);
      repeat (5) @(posedge clk);
      #2 ring_trip_clear = 1'b0;
      #1 check("q2_after", status_out_bit2, 1'b0);
      check("q1_q0_kept", {status_out_bit1, status_out_bit0}, 2'h1);
      check("ack_count", ack_count, 6);
      report_and_stop();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #3000000;
      err_count++;
      $display("Watchdog expired");
      report_and_stop();
   end
endmodule // time_slot_assigner_test

// File: tb/tsa_proc_model.sv
// Processor model driving the serial programming port of one bank.
// Assumes the bench resolves the ack wire with a weak pull-up.
`timescale 1ns/1ps

module tsa_proc_model
   import tsa_pkg::*;
(
   output logic      prog_clk,              // Serial clock, idles high
   output logic      chip_select,           // Bank select, active high
   output logic      slot_mode_serial_in,   // Mode and slot bits
   output logic      addr_status_serial_in, // Status and address bits
   input  wire logic ack_wire               // Resolved open-drain ack
);
   // ----------------------------------------------------------------
   // Serial access
   // ----------------------------------------------------------------
   initial
   begin
      prog_clk = 1'b1;                      // Stands still outside frames
      // Unknown for a moment, so the drop to low clears the receiver
      #1 chip_select = 1'b0;
      slot_mode_serial_in = 1'b0;
      addr_status_serial_in = 1'b0;
   end

   // Sends nbits of each word MSB first, then waits for the ack
   task automatic access(input logic [7:0] mw, input logic [7:0] aw,
                         input int nbits, output logic acked);
      int i;
      chip_select = 1'b1;
      #64;
      for (i = 0; i < nbits; i++)
      begin
         slot_mode_serial_in = mw[7-i];
         addr_status_serial_in = aw[7-i];
         #32 prog_clk = 1'b0;
         #32 prog_clk = 1'b1;
      end
      // Released lines flip so a stale bit cannot pass as valid
      slot_mode_serial_in = ~slot_mode_serial_in;
      addr_status_serial_in = ~addr_status_serial_in;
      // Bounded wait, a refused word never pulls the wire
      for (i = 0; i < 800 && ack_wire !== 1'b0; i++)
         #64;
      acked = (ack_wire === 1'b0);
      #16 chip_select = 1'b0;
      // Low for a full period, so back-to-back calls still clear
      #64;
   endtask
endmodule // tsa_proc_model
